/* File: verilog/fhpc_map.svh */
// register map, field positions, codes and timing figures of the head position controller
`ifndef FHPC_MAP_SVH
`define FHPC_MAP_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define FHPC_A_CMD      8'h00
`define FHPC_A_CFG      8'h04
`define FHPC_A_STAT     8'h08
`define FHPC_A_RES      8'h0C
`define FHPC_A_ID       8'h10
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FHPC_F_OP       3:0
`define FHPC_F_DS       5:4
`define FHPC_F_NCN      15:8
`define FHPC_F_CMD      15:0
`define FHPC_F_SRT      3:0
`define FHPC_F_ND       4
// ----------------------------------------------------------------
// command codes and interrupt codes
// ----------------------------------------------------------------
`define FHPC_OP_RDPOS   4'h1
`define FHPC_OP_RECAL   4'h2
`define FHPC_OP_SEEK    4'h3
`define FHPC_OP_SENSE   4'h4
`define FHPC_OP_PDOWN   4'h5
`define FHPC_OP_WAKE    4'h6
`define FHPC_IC_NORM    2'h0
`define FHPC_IC_ABN     2'h1
`define FHPC_IC_INV     2'h2
`define FHPC_IC_POLL    2'h3
// ----------------------------------------------------------------
// timing and counts
// ----------------------------------------------------------------
`define FHPC_CLK_MHZ    20
`define FHPC_STEP_W_NS  1000
`define FHPC_STEP_W_CYC ((`FHPC_STEP_W_NS * `FHPC_CLK_MHZ + 999) / 1000)
`define FHPC_SRT_UNIT_US 1000
`define FHPC_SRT_UNIT_CYC (`FHPC_SRT_UNIT_US * `FHPC_CLK_MHZ)
`define FHPC_SRT_SPAN   5'h10
`define FHPC_RECAL_MAX  8'h4F
`define FHPC_TMR_W      20
`define FHPC_NDRV       4
`define FHPC_IDX_LAST   2'h1
`endif

/* File: verilog/fhpc_pkg.sv */
// types of the head position controller
package fhpc_pkg;
`include "fhpc_map.svh"
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] c;
    logic [7:0] h;
    logic [7:0] r;
    logic [7:0] n;
  } fhpc_id_t;
  typedef struct packed {
    logic [1:0] ic;
    logic       se;
    logic       ec;
    logic       nr;
    logic       hd;
    logic [1:0] ds;
  } fhpc_st0_t;
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SP_IDLE, SP_PULSE, SP_GAP} fhpc_sp_t;
  typedef enum logic {RP_IDLE, RP_WAIT} fhpc_rp_t;
  typedef struct packed {
    fhpc_sp_t                st;
    logic                    recal;
    logic                    step;
    logic                    dir;
    logic [7:0]              present_cylinder_number;
    logic [7:0]              target_cylinder_number;
    logic [7:0]              cnt;
    logic [`FHPC_TMR_W-1:0]  tmr;
    logic                    done;
    logic                    fail;
  } fhpc_stp_t;
  typedef struct packed {
    logic                    rdy;
    logic                    resp;
    logic [31:0]             rdata;
    logic                    wr;
    logic [7:0]              waddr;
    logic [15:0]             cmd;
    logic                    cbusy;
    logic                    irq;
    logic                    poll;
    logic                    pd;
    logic                    clr;
    fhpc_rp_t                rp;
    logic                    idx_d;
    logic [1:0]              idx_n;
    fhpc_id_t                id;
    fhpc_st0_t               st0;
    logic                    ma;
    logic [7:0]              rpcn;
    logic [`FHPC_NDRV-1:0]   pend;
    logic [`FHPC_NDRV-1:0]   pfail;
    logic                    rqm;
    logic                    dma;
    logic [3:0]              step_rate_time;
    logic                    nd;
    logic [`FHPC_NDRV-1:0]   gseek;
    logic [`FHPC_NDRV-1:0]   grecal;
    logic [7:0]              target_cylinder_number;
  } fhpc_ctl_t;
endpackage

/* File: verilog/fhpc_stepper.sv */
// per-drive step and direction sequencer for seek and recalibrate
`timescale 1ns/1ps
`include "fhpc_map.svh"
module fhpc_stepper #(
  parameter int SRT_UNIT_CYC = `FHPC_SRT_UNIT_CYC,
  parameter int STEP_W_CYC   = `FHPC_STEP_W_CYC
) (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       ce,
  input  wire logic       clr,
  input  wire logic       go_seek,
  input  wire logic       go_recal,
  input  wire logic [7:0] target_cylinder_number,
  input  wire logic [3:0] step_rate_time,
  input  wire logic       trk0,
  output logic            step,
  output logic            dir,
  output logic [7:0]      present_cylinder_number,
  output logic            moving,
  output logic            done,
  output logic            fail
);
  import fhpc_pkg::*;
  fhpc_stp_t               s_r;
  fhpc_stp_t               s_nxt;
  logic [`FHPC_TMR_W-1:0]  gap_len;

  // step interval from the programmed step rate
  assign gap_len = `FHPC_TMR_W'((`FHPC_SRT_SPAN - {1'b0, step_rate_time}) * SRT_UNIT_CYC);

  function automatic fhpc_stp_t pulse(input fhpc_stp_t v);
    pulse      = v;
    pulse.step = 1'b1;
    pulse.tmr  = `FHPC_TMR_W'(STEP_W_CYC - 1);
    pulse.st   = SP_PULSE;
  endfunction

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    s_nxt.fail = 1'b0;
    if (clr) begin
      s_nxt.st   = SP_IDLE; // wake clears position
      s_nxt.step = 1'b0;
      s_nxt.present_cylinder_number  = '0;
    end else begin
      case (s_r.st)
        SP_IDLE: begin
          if (go_recal) begin
            s_nxt.recal = 1'b1;
            s_nxt.present_cylinder_number   = '0;
            s_nxt.cnt   = '0;
            s_nxt.dir   = 1'b0;
            if (trk0) begin
              s_nxt.done = 1'b1;
            end else begin
              s_nxt = pulse(s_nxt);
            end
          end else if (go_seek) begin
            s_nxt.recal = 1'b0;
            s_nxt.target_cylinder_number   = target_cylinder_number;
            s_nxt.dir   = s_r.present_cylinder_number < target_cylinder_number;
            if (s_r.present_cylinder_number == target_cylinder_number) begin
              s_nxt.done = 1'b1;
            end else begin
              s_nxt = pulse(s_nxt);
            end
          end
        end
        SP_PULSE: begin
          if (s_r.tmr != '0) begin
            s_nxt.tmr = s_r.tmr - 1'b1;
          end else begin
            s_nxt.step = 1'b0;
            s_nxt.st   = SP_GAP;
            s_nxt.tmr  = gap_len - 1'b1;
            if (s_r.recal) begin
              s_nxt.cnt = s_r.cnt + 1'b1;
            end else if (s_r.dir) begin
              s_nxt.present_cylinder_number = s_r.present_cylinder_number + 1'b1;
            end else begin
              s_nxt.present_cylinder_number = s_r.present_cylinder_number - 1'b1;
            end
          end
        end
        SP_GAP: begin
          if (s_r.tmr != '0) begin
            s_nxt.tmr = s_r.tmr - 1'b1;
          end else if (s_r.recal) begin
            if (trk0) begin
              s_nxt.done = 1'b1;
              s_nxt.st   = SP_IDLE;
            end else if (s_r.cnt == `FHPC_RECAL_MAX) begin
              s_nxt.done = 1'b1;
              s_nxt.fail = 1'b1;
              s_nxt.st   = SP_IDLE;
            end else begin
              s_nxt = pulse(s_nxt);
            end
          end else if (s_r.present_cylinder_number == s_r.target_cylinder_number) begin
            s_nxt.done = 1'b1;
            s_nxt.st   = SP_IDLE;
          end else begin
            s_nxt = pulse(s_nxt);
          end
        end
        default: s_nxt.st = SP_IDLE;
      endcase
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign step   = s_r.step;
  assign dir    = s_r.dir;
  assign present_cylinder_number    = s_r.present_cylinder_number;
  assign moving = s_r.st != SP_IDLE;
  assign done   = s_r.done;
  assign fail   = s_r.fail;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence pulse_end_s;
    ce && !clr && s_r.st == SP_PULSE && s_r.tmr == '0;
  endsequence
  recal_dir_out_a: assert property (s_r.recal && s_r.step |-> !s_r.dir)
    else $error("direction not outward during recalibrate");
  recal_limit_a: assert property (s_r.done && s_r.fail |-> s_r.recal && s_r.cnt == `FHPC_RECAL_MAX)
    else $error("recalibrate failed at wrong pulse count");
  recal_end_ok_a: assert property (ce && !clr && s_r.st == SP_GAP && s_r.tmr == '0 && s_r.recal && trk0 |=> s_r.done && !s_r.fail)
    else $error("track zero did not end recalibrate");
  seek_dir_a: assert property (ce && !clr && s_r.st == SP_IDLE && !go_recal && go_seek && s_r.present_cylinder_number != target_cylinder_number |=> s_r.step && s_r.dir == ($past(s_r.present_cylinder_number) < $past(target_cylinder_number)))
    else $error("seek direction or step wrong");
  seek_end_a: assert property (s_r.done && !s_r.recal |-> s_r.present_cylinder_number == s_r.target_cylinder_number)
    else $error("seek ended off target");
  pcn_track_a: assert property (pulse_end_s and !s_r.recal |=> s_r.present_cylinder_number == ($past(s_r.dir) ? 8'($past(s_r.present_cylinder_number) + 8'h01) : 8'($past(s_r.present_cylinder_number) - 8'h01)))
    else $error("cylinder count not updated by step");
  gap_len_a: assert property (pulse_end_s |=> s_r.st == SP_GAP && s_r.tmr == `FHPC_TMR_W'($past(gap_len) - 1'b1))
    else $error("step interval not from step rate");
endmodule // fhpc_stepper

/* File: verilog/fhpc_ctrl.sv */
// head position controller: command decode, position read, seek, sense and AHB-Lite registers
//
// Function
// - control commands move no data; only position-read, recalibrate, seek interrupt
// - position-read captures cylinder, head, sector, size of first good ID field
// - no ID mark by second index pulse: code 01, missing-mark flag, end
// - recalibrate clears the present cylinder, then samples track-zero input
// - while track-zero low during recalibrate, direction 0 and keep stepping
// - track-zero high during recalibrate sets seek-end and ends command
// - track-zero still low after 79 pulses sets seek-end and equipment-check
// - busy in command phase and while position-read waits; seeks on up to four drives overlap
// - seek steps inward with direction 1 below target, outward with 0 above
// - step interval follows the programmed step-rate time
// - after each step compare; equal sets seek-end and ends seek
// - head bit of status zero reads 0 after seek or recalibrate
// - leaving power-down clears present cylinder and status information
// - result-phase entry of data, position and format commands raises interrupt
// - end of seek or recalibrate raises interrupt
// - non-DMA mode raises interrupt whenever a data byte is needed
// - sense-interrupt-status drops interrupt and returns status zero with cause
// - cause code: polling 0/11, normal end 1/00, abnormal end 1/01
// - non-DMA bit 1 selects interrupt transfers, 0 selects DMA requests
`timescale 1ns/1ps
`include "fhpc_map.svh"
module fhpc_ctrl #(
  parameter int SRT_UNIT_CYC = `FHPC_SRT_UNIT_CYC,
  parameter int STEP_W_CYC   = `FHPC_STEP_W_CYC
) (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   ce,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic [31:0]                 hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  input  wire logic [`FHPC_NDRV-1:0]  track_zero_input,
  input  wire logic                   index_pulse_input,
  input  wire logic                   id_found,
  input  wire fhpc_pkg::fhpc_id_t     id_field,
  input  wire logic                   result_event,
  input  wire logic                   data_need,
  output logic [`FHPC_NDRV-1:0]       step_out,
  output logic [`FHPC_NDRV-1:0]       dir_out,
  output logic                        dma_req,
  output logic                        int_out,
  output logic                        id_search
);
  import fhpc_pkg::*;
  fhpc_ctl_t               s_r;
  fhpc_ctl_t               n;
  logic                    acc;
  logic [3:0]              op;
  logic [1:0]              ds;
  logic [7:0]              cmd_ncn;
  logic [`FHPC_NDRV-1:0]   step_w;
  logic [`FHPC_NDRV-1:0]   dir_w;
  logic [`FHPC_NDRV-1:0]   mov_w;
  logic [`FHPC_NDRV-1:0]   done_w;
  logic [`FHPC_NDRV-1:0]   fail_w;
  logic [7:0]              pcn_w [`FHPC_NDRV];
  logic [31:0]             rd;
  logic [1:0]              sel;
  logic                    found;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  assign acc     = hsel && htrans[1] && hready;
  assign op      = s_r.cmd[`FHPC_F_OP];
  assign ds      = s_r.cmd[`FHPC_F_DS];
  assign cmd_ncn = s_r.cmd[`FHPC_F_NCN];

  // ----------------------------------------------------------------
  // per-drive sequencers
  // ----------------------------------------------------------------
  for (genvar g = 0; g < `FHPC_NDRV; g++) begin : g_drv
    fhpc_stepper #(
      .SRT_UNIT_CYC (SRT_UNIT_CYC),
      .STEP_W_CYC   (STEP_W_CYC)
    ) u_stp (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .ce       (ce),
      .clr      (s_r.clr),
      .go_seek  (s_r.gseek[g]),
      .go_recal (s_r.grecal[g]),
      .target_cylinder_number      (s_r.target_cylinder_number),
      .step_rate_time      (s_r.step_rate_time),
      .trk0     (track_zero_input[g]),
      .step     (step_w[g]),
      .dir      (dir_w[g]),
      .present_cylinder_number      (pcn_w[g]),
      .moving   (mov_w[g]),
      .done     (done_w[g]),
      .fail     (fail_w[g])
    );
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n        = s_r;
    rd       = '0;
    sel      = '0;
    found    = 1'b0;
    n.rdy    = 1'b1;
    n.resp   = 1'b0;
    n.wr     = 1'b0;
    n.cbusy  = 1'b0;
    n.clr    = 1'b0;
    n.dma    = 1'b0;
    n.gseek  = '0;
    n.grecal = '0;
    n.idx_d  = index_pulse_input;

    // address phase: latch target, prepare read word
    if (acc) begin
      n.wr    = hwrite;
      n.waddr = haddr[7:0];
      if (!hwrite) begin
        if (haddr[7:0] == `FHPC_A_CMD) begin
          rd = 32'(s_r.cmd);
        end else if (haddr[7:0] == `FHPC_A_CFG) begin
          rd = 32'({s_r.nd, s_r.step_rate_time});
        end else if (haddr[7:0] == `FHPC_A_STAT) begin
          rd = 32'({mov_w, s_r.rp == RP_WAIT, s_r.pd, s_r.rqm, s_r.irq,
                    s_r.cbusy || s_r.rp == RP_WAIT});
        end else if (haddr[7:0] == `FHPC_A_RES) begin
          rd = 32'({s_r.ma, s_r.rpcn, s_r.st0});
        end else if (haddr[7:0] == `FHPC_A_ID) begin
          rd = s_r.id;
        end else begin
          rd = '0;
        end
        n.rdata = rd;
      end
    end

    // data phase of a write
    if (s_r.wr) begin
      if (s_r.waddr == `FHPC_A_CMD) begin
        n.cmd   = hwdata[`FHPC_F_CMD];
        n.cbusy = 1'b1; // command phase busy
      end else if (s_r.waddr == `FHPC_A_CFG) begin
        n.step_rate_time = hwdata[`FHPC_F_SRT];
        n.nd  = hwdata[`FHPC_F_ND];
      end
    end

    // command execution, one cycle after the command write
    if (s_r.cbusy) begin
      if (s_r.pd) begin
        if (op == `FHPC_OP_WAKE) begin
          n.pd    = 1'b0;
          n.clr   = 1'b1;
          n.pend  = '0;
          n.pfail = '0;
          n.st0   = '0;
          n.ma    = 1'b0;
          n.rpcn  = '0;
        end
      end else if (op == `FHPC_OP_RDPOS) begin
        n.rp     = RP_WAIT;
        n.idx_n  = '0;
        n.st0.ds = ds;
      end else if (op == `FHPC_OP_RECAL) begin
        n.grecal[ds] = 1'b1;
      end else if (op == `FHPC_OP_SEEK) begin
        n.gseek[ds] = 1'b1; // execution runs without busy
        n.target_cylinder_number       = cmd_ncn;
      end else if (op == `FHPC_OP_SENSE) begin
        n.irq = 1'b0;
        for (int i = `FHPC_NDRV - 1; i >= 0; i--) begin
          if (s_r.pend[i]) begin
            sel   = 2'(i);
            found = 1'b1;
          end
        end
        n.st0.nr = 1'b0;
        n.st0.hd = 1'b0;
        if (found) begin
          n.st0.ic   = s_r.pfail[sel] ? `FHPC_IC_ABN : `FHPC_IC_NORM;
          n.st0.se   = 1'b1;
          n.st0.ec   = s_r.pfail[sel];
          n.st0.ds   = sel;
          n.rpcn     = pcn_w[sel];
          n.pend[sel] = 1'b0;
        end else if (s_r.poll) begin
          n.st0.ic = `FHPC_IC_POLL;
          n.st0.se = 1'b0;
          n.st0.ec = 1'b0;
          n.poll   = 1'b0;
        end else begin
          n.st0.ic = `FHPC_IC_INV;
          n.st0.se = 1'b0;
          n.st0.ec = 1'b0;
        end
      end else if (op == `FHPC_OP_PDOWN) begin
        n.pd = 1'b1;
      end
      // remaining codes finish silently
    end

    // position read: first ID field or two index pulses
    if (s_r.rp == RP_WAIT) begin
      if (id_found) begin
        n.id     = id_field;
        n.st0.ic = `FHPC_IC_NORM;
        n.st0.se = 1'b0;
        n.st0.ec = 1'b0;
        n.ma     = 1'b0;
        n.rp     = RP_IDLE;
        n.irq    = 1'b1;
      end else if (index_pulse_input && !s_r.idx_d) begin
        if (s_r.idx_n == `FHPC_IDX_LAST) begin
          n.st0.ic = `FHPC_IC_ABN;
          n.st0.se = 1'b0;
          n.st0.ec = 1'b0;
          n.ma     = 1'b1;
          n.rp     = RP_IDLE;
          n.irq    = 1'b1;
        end else begin
          n.idx_n = s_r.idx_n + 1'b1;
        end
      end
    end

    // drive completions, set wins over the sense clear
    for (int i = 0; i < `FHPC_NDRV; i++) begin
      if (done_w[i]) begin
        n.pend[i]  = 1'b1;
        n.pfail[i] = fail_w[i];
        n.irq      = 1'b1;
      end
    end

    // data command result phase and byte requests
    if (result_event) begin
      n.irq = 1'b1;
    end
    n.rqm = data_need && s_r.nd;
    if (data_need) begin
      if (s_r.nd) begin
        n.irq = 1'b1;
      end else begin
        n.dma = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r      <= '0;
      s_r.rdy  <= 1'b1;
      s_r.irq  <= 1'b1; // single polling interrupt after reset
      s_r.poll <= 1'b1;
    end else if (ce) begin
      s_r <= n;
    end
  end

  // outputs
  assign hrdata    = s_r.rdata;
  assign hreadyout = s_r.rdy;
  assign hresp     = s_r.resp;
  assign int_out   = s_r.irq;
  assign dma_req   = s_r.dma;
  assign id_search = s_r.rp;
  assign step_out  = step_w;
  assign dir_out   = dir_w;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence exec_s(logic [3:0] code);
    ce && s_r.cbusy && !s_r.pd && op == code;
  endsequence
  sequence idx_rise_s;
    ce && s_r.rp == RP_WAIT && !id_found && index_pulse_input && !s_r.idx_d;
  endsequence
  id_capture_a: assert property (ce && s_r.rp == RP_WAIT && id_found |=> s_r.id == $past(id_field) && s_r.irq && s_r.rp == RP_IDLE)
    else $error("position read did not capture ID field");
  id_missing_a: assert property (idx_rise_s and s_r.idx_n == `FHPC_IDX_LAST |=> s_r.st0.ic == `FHPC_IC_ABN && s_r.ma && s_r.irq)
    else $error("missing address mark not reported");
  sense_drop_a: assert property (exec_s(`FHPC_OP_SENSE) and done_w == '0 && !result_event && !data_need && s_r.rp == RP_IDLE |=> !s_r.irq)
    else $error("sense did not drop interrupt");
  sense_cause_a: assert property (exec_s(`FHPC_OP_SENSE) and s_r.pend[0] && !s_r.pfail[0] |=> s_r.st0.se && s_r.st0.ic == `FHPC_IC_NORM && !s_r.st0.hd && s_r.st0.ds == 2'h0)
    else $error("sense status wrong after seek end");
  result_irq_a: assert property (ce && result_event |=> s_r.irq)
    else $error("result phase without interrupt");
  seek_done_irq_a: assert property (ce && done_w[0] |=> s_r.irq && s_r.pend[0] && s_r.pfail[0] == $past(fail_w[0]))
    else $error("seek end did not raise interrupt");
  xfer_mode_a: assert property (ce && data_need |=> ($past(s_r.nd) ? (s_r.irq && !s_r.dma) : s_r.dma))
    else $error("byte request signalled the wrong way");
  seek_launch_a: assert property (exec_s(`FHPC_OP_SEEK) |=> !s_r.cbusy ##0 $onehot(s_r.gseek) && s_r.target_cylinder_number == $past(cmd_ncn))
    else $error("seek not launched without busy");
  wake_clear_a: assert property (ce && s_r.cbusy && s_r.pd && op == `FHPC_OP_WAKE |=> s_r.pend == '0 && s_r.st0 == '0 ##2 !ce || (pcn_w[0] == 8'h00 && pcn_w[3] == 8'h00))
    else $error("wake did not clear position and status");
endmodule // fhpc_ctrl

/* File: tb/fhpc_drive_model.sv */
// four floppy drives: head position follows step and direction, track zero flag
`timescale 1ns/1ps
module fhpc_drive_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [3:0] step,
  input  wire logic [3:0] dir,
  output logic      [3:0] trk0
);
  logic [7:0] pos_r [4];
  logic [3:0] step_d_r;
  // heads move one track on each rising step edge, stop at track zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pos_r    <= '{8'h02, 8'h5A, 8'h00, 8'h00};
      step_d_r <= 4'h0;
    end else begin
      step_d_r <= step;
      for (int i = 0; i < 4; i++) begin
        if (step[i] && !step_d_r[i] && dir[i]) pos_r[i] <= pos_r[i] + 8'h01;
        else if (step[i] && !step_d_r[i] && pos_r[i] != 8'h00) pos_r[i] <= pos_r[i] - 8'h01;
      end
    end
  end
  // track zero sensor per drive, high at track zero
  always_comb for (int i = 0; i < 4; i++) trk0[i] = (pos_r[i] == 8'h00);
endmodule // fhpc_drive_model

/* File: tb/tb_fhpc_ctrl.sv */
// self-checking bench of the head position controller over AHB-Lite
`timescale 1ns/1ps
module tb_fhpc_ctrl;
  import fhpc_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, idx = 0, idf = 0, rev = 0, dneed = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  logic hready, hresp, dma_req, int_out, id_search;
  logic [3:0] trk0, step, dir, st_d = 0, edir = 0;
  fhpc_id_t idv = '0;
  int nst[4] = '{0, 0, 0, 0}, t0[4], gap[4], cyc = 0, errors = 0, n_compared = 0;
  always #25 hclk = ~hclk;
  fhpc_ctrl #(.SRT_UNIT_CYC(4), .STEP_W_CYC(2)) fhpc_ctrl_inst (.hclk(hclk),
    .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .track_zero_input(trk0), .index_pulse_input(idx),
    .id_found(idf), .id_field(idv), .result_event(rev), .data_need(dneed), .step_out(step),
    .dir_out(dir), .dma_req(dma_req), .int_out(int_out), .id_search(id_search));
  fhpc_drive_model fhpc_drive_model_inst (.hclk(hclk), .hresetn(hresetn), .step(step),
    .dir(dir), .trk0(trk0));
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  // counts step pulses, spacing and direction per drive
  always @(posedge hclk) begin
    cyc++;
    st_d <= step;
    for (int i = 0; i < 4; i++) if (step[i] && !st_d[i]) begin
      gap[i] = cyc - t0[i];
      t0[i] = cyc;
      nst[i]++;
      chk("dir", {31'h0, dir[i]}, {31'h0, edir[i]});
    end
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic cmd(input logic [3:0] op, input logic [1:0] ds, input logic [7:0] c);
    xfer(1'b1, 8'h00, {16'h0, c, 2'h0, ds, op});
    repeat (2) @(posedge hclk);
  endtask
  task automatic sense(input logic [7:0] s, input logic [7:0] c);
    cmd(4'h4, 2'h0, 8'h00);
    xfer(1'b0, 8'h0C, 32'h0);
    chk("st0", {24'h0, rd[7:0]}, {24'h0, s});
    if (c !== 8'hFF) chk("cyl", {24'h0, rd[15:8]}, {24'h0, c});
    chk("irq_off", {31'h0, int_out}, 32'h0);
  endtask
  task automatic wint();
    for (int k = 0; k < 3000 && int_out !== 1'b1; k++) @(posedge hclk);
    chk("irq_on", {31'h0, int_out}, 32'h1);
  endtask
  task automatic give_verdict();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // watchdog against a hung wait
  initial begin
    repeat (20000) @(posedge hclk);
    errors++;
    give_verdict();
  end
  // main sequence
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    sense(8'hC0, 8'h00);
    xfer(1'b1, 8'h04, 32'h0000000F);
    xfer(1'b0, 8'h04, 32'h0);
    chk("cfg", rd, 32'h0000000F);
    edir = 4'h9;
    cmd(4'h3, 2'h0, 8'h05);
    xfer(1'b0, 8'h08, 32'h0);
    chk("busy", {31'h0, rd[0]}, 32'h0);
    wint();
    chk("n_in", nst[0], 5);
    chk("gap_f", gap[0], 6);
    sense(8'h20, 8'h05);
    xfer(1'b1, 8'h04, 32'h0000000E);
    edir = 4'h8;
    nst[0] = 0;
    cmd(4'h3, 2'h0, 8'h02);
    wint();
    chk("n_out", nst[0], 3);
    chk("gap_e", gap[0], 10);
    sense(8'h20, 8'h02);
    xfer(1'b1, 8'h04, 32'h0000000F);
    nst[0] = 0;
    cmd(4'h2, 2'h0, 8'h00);
    wint();
    chk("n_rc0", nst[0], 4);
    sense(8'h20, 8'h00);
    cmd(4'h2, 2'h1, 8'h00);
    cmd(4'h3, 2'h3, 8'h03);
    wint();
    sense(8'h23, 8'h03);
    wint();
    chk("n_rc1", nst[1], 79);
    sense(8'h71, 8'hFF);
    cmd(4'h1, 2'h0, 8'h00);
    repeat (4) begin
      idx <= ~idx;
      repeat (3) @(posedge hclk);
    end
    wint();
    xfer(1'b0, 8'h0C, 32'h0);
    chk("ma", {31'h0, rd[16]}, 32'h00000001);
    chk("ic_abn", {30'h0, rd[7:6]}, 32'h00000001);
    sense(8'h80, 8'hFF);
    cmd(4'h1, 2'h0, 8'h00);
    chk("srch", {31'h0, id_search}, 32'h1);
    idv <= 32'h12345678;
    idf <= 1'b1;
    @(posedge hclk);
    idf <= 1'b0;
    wint();
    xfer(1'b0, 8'h10, 32'h0);
    chk("id", rd, 32'h12345678);
    sense(8'h80, 8'hFF);
    rev <= 1'b1;
    @(posedge hclk);
    rev <= 1'b0;
    wint();
    sense(8'h80, 8'hFF);
    cmd(4'h5, 2'h0, 8'h00);
    xfer(1'b0, 8'h08, 32'h0);
    chk("pd", {31'h0, rd[3]}, 32'h1);
    cmd(4'h6, 2'h0, 8'h00);
    xfer(1'b0, 8'h0C, 32'h0);
    chk("wake", {15'h0, rd[16:0]}, 32'h0);
    dneed <= 1'b1;
    repeat (2) @(negedge hclk);
    chk("dreq", {31'h0, dma_req}, 32'h1);
    dneed <= 1'b0;
    xfer(1'b1, 8'h04, 32'h0000001F);
    dneed <= 1'b1;
    repeat (2) @(posedge hclk);
    xfer(1'b0, 8'h08, 32'h0);
    chk("rqm", {31'h0, rd[2]}, 32'h1);
    chk("nd_irq", {31'h0, rd[1]}, 32'h1);
    chk("nd_dma", {31'h0, dma_req}, 32'h0);
    give_verdict();
  end
endmodule // tb_fhpc_ctrl
